// ### sacm_pkg.sv
// Constants, types and helpers shared by the converter manager files.
// Assumes a 10 MHz core clock; all times below are turned into cycles of it.
package sacm_pkg;
    localparam int CLK_PERIOD_NS = 100;
    localparam int SAMPLE_PERIOD_NS = 29500;
    localparam int SAMPLE_FREQ_HZ = 33850;
    localparam int SAMPLE_PERIOD_CYC = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
    // Hold window: middle half of the period, start rounded up
    localparam int HOLD_START_CYC = (SAMPLE_PERIOD_CYC + 3) / 4;
    localparam int HOLD_END_CYC = HOLD_START_CYC + SAMPLE_PERIOD_CYC / 2;
    localparam int HR_CONV_NS = 130000;
    localparam int HR_CONV_CYC = (HR_CONV_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HR_BITS = 8;
    localparam int SAR_BITS = 16;
    localparam int SAR_EDGES = 17;
    localparam logic [15:0] SAR_RESET_WORD = 16'h7fff;
    localparam logic [15:0] OUT_WORD_RESET = 16'h7fff;
    localparam logic [15:0] BUS_MSB_MASK = 16'h8000;
    localparam int HR_STEPS = 5;
    localparam int HR_TOP_BIT = 14;
    localparam int PEAK_DECAY_SHIFT = 6;
    // Register map, word addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h1;
    localparam logic [3:0] REG_HR_CODE = 4'h2;
    localparam logic [3:0] REG_RESULT = 4'h3;
    localparam int CTRL_START_BIT = 0;
    localparam int CTRL_MUTE_BIT = 1;
    localparam logic CTRL_MUTE_RESET = 1'b1;

    typedef enum logic [1:0] {
        PH_ACQ = 2'b00,
        PH_HOLD = 2'b01
    } sacm_phase_t;

    typedef enum logic [1:0] {
        HR_IDLE = 2'b00,
        HR_RUN = 2'b01
    } sacm_hr_state_t;

    // Toggle the MSB between converter and bus coding
    function automatic logic [15:0] sacm_recode(input logic [15:0] w);
        return w ^ BUS_MSB_MASK;
    endfunction

    // Magnitude of a complementary two's complement bus word
    function automatic logic [15:0] sacm_magnitude(input logic [15:0] w);
        logic [15:0] v;
        v = ~w;
        return v[15] ? 16'(-v) : v;
    endfunction
endpackage

// ### sacm_sar_if.sv
// Signals between the control top and the approximation engine.
// Assumes both ends run on the same core clock.
`timescale 1ns/1ps
interface sacm_sar_if;
    logic bit_edge;
    logic start_low;
    logic cmp_bit;
    logic [15:0] sar_value;
    logic [15:0] result;
    logic done;
    modport engine (input bit_edge, input start_low, input cmp_bit, output sar_value, output result, output done);
    modport ctrl (output bit_edge, output start_low, output cmp_bit, input sar_value, input result, input done);
endinterface // sacm_sar_if

// ### sacm_sar_engine.sv
// Sixteen-bit successive approximation register and result holding register.
// Assumes synchronised, edge-detected bit clock pulses from the top.
`timescale 1ns/1ps
module sacm_sar_engine
    import sacm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    sacm_sar_if.engine sar
);
    logic [15:0] sar_reg;
    logic [15:0] result_reg;
    logic done_reg;
    logic [4:0] edge_cnt_reg;
    logic [3:0] trial_reg;

    always_ff @(posedge core_clk) begin
        if (rst) begin
            sar_reg <= SAR_RESET_WORD;
            edge_cnt_reg <= 5'h00;
            trial_reg <= 4'hf;
        end else if (sar.bit_edge) begin
            if (sar.start_low) begin
                sar_reg <= SAR_RESET_WORD;
                edge_cnt_reg <= 5'h01;
                trial_reg <= 4'hf;
            end else if (edge_cnt_reg != 5'h00 && edge_cnt_reg < 5'(SAR_EDGES)) begin
                // Comparator taken only on a settled bit edge
                sar_reg[trial_reg] <= sar.cmp_bit;
                if (trial_reg != 4'h0) begin
                    sar_reg[trial_reg - 4'h1] <= 1'b0;
                end
                trial_reg <= trial_reg - 4'h1;
                edge_cnt_reg <= (edge_cnt_reg == 5'(SAR_EDGES - 1)) ? 5'h00 : edge_cnt_reg + 5'h01;
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            result_reg <= SAR_RESET_WORD;
            done_reg <= 1'b0;
        end else begin
            done_reg <= 1'b0;
            if (sar.bit_edge && !sar.start_low && edge_cnt_reg == 5'(SAR_EDGES - 1)) begin
                result_reg <= {sar_reg[15:1], sar.cmp_bit};
                done_reg <= 1'b1;
            end
        end
    end

    assign sar.sar_value = sar_reg;
    assign sar.result = result_reg;
    assign sar.done = done_reg;
endmodule // sacm_sar_engine

// ### sacm_converter_manager.sv
// Converter manager top: sample timing, DAC selects, bus recoding, headroom.
// Assumes pins arrive asynchronously; a plain register port serves the master processor.
`timescale 1ns/1ps
module sacm_converter_manager
    import sacm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic conversion_start_n,
    input wire logic conversion_bit_clock,
    input wire logic comparator_bit,
    input wire logic input_word_enable,
    input wire logic output_word_latch,
    input wire logic test_mode_jumper,
    input wire logic overload_flag,
    input wire logic headroom_adc_clock,
    input wire logic [15:0] digital_audio_bus_in,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [15:0] reg_rdata,
    output logic [15:0] digital_audio_bus_out,
    output logic digital_audio_bus_oe,
    output logic sample_hold_strobe,
    output logic dac_input_select,
    output logic dac_input_select_n,
    output logic [15:0] dac_word,
    output logic [HR_STEPS-1:0] headroom_led
);
    localparam int SYNC_W = 24;

    sacm_sar_if sar_bus ();

    logic [SYNC_W-1:0] pin_meta_reg;
    logic [SYNC_W-1:0] pin_sync_reg;
    logic bit_clk_d_reg;
    logic latch_d_reg;
    logic hr_clk_d_reg;
    logic [8:0] phase_cnt_reg;
    sacm_phase_t phase_reg;
    logic [15:0] out_word_reg;
    logic [15:0] peak_reg;
    sacm_hr_state_t hr_state_reg;
    logic [10:0] hr_cyc_reg;
    logic [3:0] hr_bit_reg;
    logic [7:0] hr_code_reg;
    logic hr_done_reg;
    logic mute_reg;
    logic hr_start;
    logic hr_finish;

    // Synchronised pins
    logic s_bit_clk;
    logic s_start_n;
    logic s_cmp;
    logic s_in_en;
    logic s_latch;
    logic s_test;
    logic s_overload_flag;
    logic s_hr_clk;
    logic [15:0] s_bus_in;

    // Two-stage synchroniser for every pin input; reset to idle levels, only start is high
    always_ff @(posedge core_clk) begin
        if (rst) begin
            pin_meta_reg <= 24'h000002;
            pin_sync_reg <= 24'h000002;
        end else begin
            pin_meta_reg <= {digital_audio_bus_in, headroom_adc_clock, overload_flag, test_mode_jumper,
                             output_word_latch, input_word_enable, comparator_bit, conversion_start_n,
                             conversion_bit_clock};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    assign s_bit_clk = pin_sync_reg[0];
    assign s_start_n = pin_sync_reg[1];
    assign s_cmp = pin_sync_reg[2];
    assign s_in_en = pin_sync_reg[3];
    assign s_latch = pin_sync_reg[4];
    assign s_test = pin_sync_reg[5];
    assign s_overload_flag = pin_sync_reg[6];
    assign s_hr_clk = pin_sync_reg[7];
    assign s_bus_in = pin_sync_reg[23:8];

    // Rising-edge detectors on synchronised clocks and strobes
    always_ff @(posedge core_clk) begin
        if (rst) begin
            bit_clk_d_reg <= 1'b1;
            latch_d_reg <= 1'b1;
            hr_clk_d_reg <= 1'b1;
        end else begin
            bit_clk_d_reg <= s_bit_clk;
            latch_d_reg <= s_latch;
            hr_clk_d_reg <= s_hr_clk;
        end
    end

    assign sar_bus.bit_edge = s_bit_clk & ~bit_clk_d_reg;
    assign sar_bus.start_low = ~s_start_n;
    assign sar_bus.cmp_bit = s_cmp;

    sacm_sar_engine u_sar (
        .core_clk(core_clk),
        .rst(rst),
        .sar(sar_bus.engine)
    );

    // Sample period counter
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_cnt_reg <= 9'h000;
        end else if (phase_cnt_reg == 9'(SAMPLE_PERIOD_CYC - 1)) begin
            phase_cnt_reg <= 9'h000;
        end else begin
            phase_cnt_reg <= phase_cnt_reg + 9'h001;
        end
    end

    // Hold during the middle half of each period
    always_ff @(posedge core_clk) begin
        if (rst) begin
            phase_reg <= PH_ACQ;
        end else begin
            case (phase_reg)
                PH_ACQ: begin
                    if (phase_cnt_reg == 9'(HOLD_START_CYC - 1)) begin
                        phase_reg <= PH_HOLD;
                    end
                end
                PH_HOLD: begin
                    if (phase_cnt_reg == 9'(HOLD_END_CYC - 1)) begin
                        phase_reg <= PH_ACQ;
                    end
                end
                default: begin
                    phase_reg <= PH_ACQ;
                end
            endcase
        end
    end

    // Strobe and selects move on the same edge
    always_ff @(posedge core_clk) begin
        if (rst) begin
            sample_hold_strobe <= 1'b1;
            dac_input_select <= 1'b0;
            dac_input_select_n <= 1'b1;
        end else begin
            sample_hold_strobe <= (phase_reg != PH_HOLD);
            if (phase_reg == PH_HOLD || mute_reg) begin
                dac_input_select <= 1'b0;
                dac_input_select_n <= 1'b1;
            end else begin
                dac_input_select <= 1'b1;
                dac_input_select_n <= 1'b0;
            end
        end
    end

    // DAC word: trial value while holding, output word otherwise
    always_ff @(posedge core_clk) begin
        if (rst) begin
            dac_word <= SAR_RESET_WORD;
        end else if (phase_reg == PH_HOLD) begin
            dac_word <= sar_bus.sar_value;
        end else begin
            dac_word <= out_word_reg;
        end
    end

    // Output word register, separate from the conversion result
    always_ff @(posedge core_clk) begin
        if (rst) begin
            out_word_reg <= OUT_WORD_RESET;
        end else if (s_test) begin
            if (sar_bus.done) begin
                out_word_reg <= sar_bus.result;
            end
        end else if (s_latch && !latch_d_reg) begin
            out_word_reg <= sacm_recode(s_bus_in);
        end
    end

    // Result onto the bus only while enabled
    always_ff @(posedge core_clk) begin
        if (rst) begin
            digital_audio_bus_out <= 16'h0000;
            digital_audio_bus_oe <= 1'b0;
        end else begin
            digital_audio_bus_out <= sacm_recode(sar_bus.result);
            digital_audio_bus_oe <= s_in_en;
        end
    end

    // Peak hold with slow decay, updated per conversion
    always_ff @(posedge core_clk) begin
        if (rst) begin
            peak_reg <= 16'h0000;
        end else if (sar_bus.done) begin
            if (sacm_magnitude(sacm_recode(sar_bus.result)) > peak_reg) begin
                peak_reg <= sacm_magnitude(sacm_recode(sar_bus.result));
            end else begin
                peak_reg <= peak_reg - (peak_reg >> PEAK_DECAY_SHIFT);
            end
        end
    end

    // Point display, one indicator per 6 dB step
    always_ff @(posedge core_clk) begin
        if (rst) begin
            headroom_led <= '0;
        end else if (s_overload_flag) begin
            headroom_led <= HR_STEPS'(1);
        end else begin
            headroom_led <= '0;
            for (int k = HR_STEPS - 1; k >= 0; k--) begin
                if (peak_reg >= (16'h0001 << (HR_TOP_BIT - k))) begin
                    headroom_led <= HR_STEPS'(1) << k;
                end
            end
        end
    end

    assign hr_start = reg_write && reg_addr == REG_CTRL && reg_wdata[CTRL_START_BIT];
    assign hr_finish = hr_state_reg == HR_RUN && hr_bit_reg == 4'(HR_BITS) && hr_cyc_reg == 11'h000;

    // Headroom level converter: its own clock steps the bits, a core-clock timer sets the end
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hr_state_reg <= HR_IDLE;
            hr_cyc_reg <= 11'h000;
            hr_bit_reg <= 4'h0;
            hr_code_reg <= 8'h00;
        end else begin
            case (hr_state_reg)
                HR_IDLE: begin
                    if (hr_start) begin
                        hr_state_reg <= HR_RUN;
                        hr_cyc_reg <= 11'(HR_CONV_CYC - 1);
                        hr_bit_reg <= 4'h0;
                    end
                end
                HR_RUN: begin
                    if (hr_cyc_reg != 11'h000) begin
                        hr_cyc_reg <= hr_cyc_reg - 11'h001;
                    end
                    if (s_hr_clk && !hr_clk_d_reg && hr_bit_reg != 4'(HR_BITS)) begin
                        hr_bit_reg <= hr_bit_reg + 4'h1;
                    end
                    if (hr_finish) begin
                        hr_code_reg <= (peak_reg >= 16'h8000) ? 8'hff : peak_reg[14:7];
                        hr_state_reg <= HR_IDLE;
                    end
                end
                default: begin
                    hr_state_reg <= HR_IDLE;
                end
            endcase
        end
    end

    // Done flag: set wins over the clear by reading the code
    always_ff @(posedge core_clk) begin
        if (rst) begin
            hr_done_reg <= 1'b0;
        end else if (hr_finish) begin
            hr_done_reg <= 1'b1;
        end else if (reg_read && reg_addr == REG_HR_CODE) begin
            hr_done_reg <= 1'b0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            mute_reg <= CTRL_MUTE_RESET;
        end else if (reg_write && reg_addr == REG_CTRL) begin
            mute_reg <= reg_wdata[CTRL_MUTE_BIT];
        end
    end

    // Read data stand for one cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reg_rdata <= 16'h0000;
        end else if (reg_read) begin
            case (reg_addr)
                REG_CTRL: reg_rdata <= {14'h0000, mute_reg, 1'b0};
                REG_STATUS: reg_rdata <= {7'h00, headroom_led, s_overload_flag, s_test,
                                          hr_done_reg, hr_state_reg == HR_RUN};
                REG_HR_CODE: reg_rdata <= {8'h00, hr_code_reg};
                REG_RESULT: reg_rdata <= sacm_recode(sar_bus.result);
                default: reg_rdata <= 16'h0000;
            endcase
        end else begin
            reg_rdata <= 16'h0000;
        end
    end
endmodule // sacm_converter_manager

// ### sacm_converter_manager_props.sv
// Checker for the converter manager top ports: strobe timing, selects, bus, headroom.
// Assumes it is bound into the top module; mute is tracked from register writes.
`timescale 1ns/1ps
module sacm_converter_manager_props
    import sacm_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input wire logic input_word_enable,
    input wire logic overload_flag,
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [15:0] reg_rdata,
    input wire logic [15:0] digital_audio_bus_out,
    input wire logic digital_audio_bus_oe,
    input wire logic sample_hold_strobe,
    input wire logic dac_input_select,
    input wire logic dac_input_select_n,
    input wire logic [HR_STEPS-1:0] headroom_led
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);
    logic mute_q;
    // Shadow of the mute control bit
    always_ff @(posedge core_clk) begin
        if (rst) begin
            mute_q <= CTRL_MUTE_RESET;
        end else if (reg_write && reg_addr == REG_CTRL) begin
            mute_q <= reg_wdata[CTRL_MUTE_BIT];
        end
    end
    a_strobe_period: assert property ($fell(sample_hold_strobe) |-> ##295 $fell(sample_hold_strobe))
        else $error("strobe period wrong");
    a_hold_width: assert property ($fell(sample_hold_strobe) |-> (!sample_hold_strobe throughout ##146 1'b1) ##1 sample_hold_strobe)
        else $error("hold width wrong");
    a_sample_width: assert property ($rose(sample_hold_strobe) |-> (sample_hold_strobe throughout ##147 1'b1) ##1 !sample_hold_strobe)
        else $error("sample width wrong");
    a_hold_selects: assert property (!sample_hold_strobe |-> !dac_input_select && dac_input_select_n)
        else $error("selects wrong in hold");
    a_select_pair: assert property (dac_input_select != dac_input_select_n)
        else $error("selects not complementary");
    a_select_rise: assert property ($rose(dac_input_select) |-> $rose(sample_hold_strobe))
        else $error("select rose without strobe");
    a_mute_blocks: assert property (mute_q [*3] |-> !dac_input_select)
        else $error("select switched while muted");
    a_bus_on: assert property (input_word_enable [*4] |-> digital_audio_bus_oe)
        else $error("bus not enabled");
    a_bus_off: assert property (!input_word_enable [*4] |-> !digital_audio_bus_oe)
        else $error("bus driven without enable");
    a_result_bus: assert property ($past(reg_read) && $past(reg_addr) == REG_RESULT |-> reg_rdata == digital_audio_bus_out)
        else $error("result and bus word differ");
    a_overload_led: assert property (overload_flag [*4] |-> headroom_led == 5'h01)
        else $error("overload not on top step");
    a_led_onehot: assert property ($onehot0(headroom_led))
        else $error("headroom display not one-hot");
    c_unmute: cover property ($rose(dac_input_select));
    c_bus: cover property ($rose(digital_audio_bus_oe));
    c_overload: cover property (overload_flag ##4 headroom_led == 5'h01);
endmodule // sacm_converter_manager_props

// ### sacm_analog_model.sv
// Behavioural sample-hold, DAC and comparator on the converter's far side.
// Assumes the bench sets the input level before each hold begins.
`timescale 1ns/1ps
module sacm_analog_model (
    input wire logic sample_hold_strobe,
    input wire logic [15:0] dac_word,
    input wire logic [15:0] level,
    output logic comparator_bit
);
    logic [15:0] held = 16'h0000;
    // Capture level on entry to hold
    always @(negedge sample_hold_strobe) held <= level;
    // High while signal lies above the trial code
    assign comparator_bit = held > dac_word;
endmodule // sacm_analog_model

// ### sacm_converter_manager_bench.sv
// Self-checking bench: conversions, bus output, mute, latch, self-test, headroom.
// Assumes the analog model answers the comparator from the held level.
`timescale 1ns/1ps
module sacm_converter_manager_bench
    import sacm_pkg::*;
;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic conversion_start_n = 1'b1;
    logic conversion_bit_clock = 1'b0;
    logic comparator_bit, input_word_enable = 1'b0, output_word_latch = 1'b0;
    logic test_mode_jumper = 1'b0, overload_flag = 1'b0, headroom_adc_clock, reg_write = 1'b0, reg_read = 1'b0;
    logic [3:0] hr_div = 4'h0, reg_addr = 4'h0;
    logic [15:0] digital_audio_bus_in = 16'h0000, reg_wdata = 16'h0000, level = 16'h0000;
    logic [15:0] reg_rdata, digital_audio_bus_out, dac_word, d;
    logic digital_audio_bus_oe, sample_hold_strobe, dac_input_select, dac_input_select_n;
    logic [HR_STEPS-1:0] headroom_led;
    logic [15:0] vals [4] = '{16'hffff, 16'h8000, 16'h7fff, 16'h0000};
    int error_cnt = 0;
    int samples_checked = 0;
    int n;
    sacm_converter_manager u_dut (.core_clk, .rst, .conversion_start_n, .conversion_bit_clock, .comparator_bit,
        .input_word_enable, .output_word_latch, .test_mode_jumper, .overload_flag, .headroom_adc_clock,
        .digital_audio_bus_in, .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .digital_audio_bus_out,
        .digital_audio_bus_oe, .sample_hold_strobe, .dac_input_select, .dac_input_select_n, .dac_word, .headroom_led);
    sacm_analog_model u_model (.sample_hold_strobe, .dac_word, .level, .comparator_bit);
    initial forever #50 core_clk = ~core_clk;
    always @(posedge core_clk) hr_div <= hr_div + 4'h1;
    assign headroom_adc_clock = hr_div[3];
    task automatic conclude();
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] w);
        reg_addr <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a, output logic [15:0] r);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge core_clk);
        reg_read <= 1'b0;
        @(posedge core_clk);
        r = reg_rdata;
    endtask
    task automatic wait_lvl(input logic v);
        repeat (400) if (sample_hold_strobe !== v) @(posedge core_clk);
    endtask
    // Sequencer role: start low on the first of 17 bit-clock edges
    task automatic conv(input logic [15:0] t, input logic sel);
        logic [15:0] e;
        int b;
        level <= t;
        wait_lvl(1'b1);
        wait_lvl(1'b0);
        conversion_start_n <= 1'b0;
        cyc(2);
        for (int j = 1; j <= 17; j++) begin
            conversion_bit_clock <= 1'b1;
            cyc(4);
            conversion_bit_clock <= 1'b0;
            conversion_start_n <= 1'b1;
            cyc(3);
            b = 17 - j;
            e = (j == 1) ? SAR_RESET_WORD : (t & (16'hffff << b)) | (((16'h1 << b) - 16'h1) & ~(16'h1 << (b - 1)));
            check(dac_word, e);
            cyc(1);
        end
        wait_lvl(1'b1);
        cyc(3);
        check({dac_input_select, dac_input_select_n}, {sel, ~sel});
        rd(REG_RESULT, d);
        check(d, t ^ 16'h8000);
        input_word_enable <= 1'b1;
        cyc(5);
        check(digital_audio_bus_oe, 1'b1);
        check(digital_audio_bus_out, t ^ 16'h8000);
        input_word_enable <= 1'b0;
        cyc(5);
        check(digital_audio_bus_oe, 1'b0);
    endtask
    initial begin
        repeat (20000) @(posedge core_clk);
        error_cnt++;
        conclude();
    end
    initial begin
        cyc(5);
        rst <= 1'b0;
        cyc(1);
        check({sample_hold_strobe, dac_input_select, dac_input_select_n, digital_audio_bus_oe}, 4'b1010);
        check(dac_word, 16'h7fff);
        overload_flag <= 1'b1;
        cyc(5);
        check(headroom_led, 5'h01);
        overload_flag <= 1'b0;
        cyc(5);
        check(headroom_led, 5'h00);
        rd(4'hf, d);
        check(d, 16'h0000);
        conv(16'h1234, 1'b0);
        wait_lvl(1'b0);
        wr(REG_CTRL, 16'h0000);
        foreach (vals[i]) conv(vals[i], 1'b1);
        check(headroom_led, 5'h01);
        wr(REG_CTRL, 16'h0001);
        d = 16'h0000;
        for (n = 0; n < 1000 && d[1] !== 1'b1; n++) rd(REG_STATUS, d);
        check(16'(n * 2 + 4 >= HR_CONV_CYC && n * 2 <= HR_CONV_CYC + 100), 16'h1);
        rd(REG_HR_CODE, d);
        check(d[7:6], 2'b11);
        rd(REG_STATUS, d);
        check(d[1], 1'b0);
        wait_lvl(1'b0);
        wait_lvl(1'b1);
        digital_audio_bus_in <= 16'h4321;
        cyc(3);
        output_word_latch <= 1'b1;
        cyc(4);
        output_word_latch <= 1'b0;
        cyc(4);
        check(dac_word, 16'hc321);
        test_mode_jumper <= 1'b1;
        conv(16'h5a5a, 1'b1);
        check(dac_word, 16'h5a5a);
        conclude();
    end
endmodule // sacm_converter_manager_bench
bind sacm_converter_manager sacm_converter_manager_props u_props (.core_clk, .rst, .input_word_enable, .overload_flag,
    .reg_addr, .reg_wdata, .reg_write, .reg_read, .reg_rdata, .digital_audio_bus_out, .digital_audio_bus_oe,
    .sample_hold_strobe, .dac_input_select, .dac_input_select_n, .headroom_led);
